// *** design/usp_pkg.sv ***
package usp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // clock and bit timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned BAUD_DEFAULT = 115_200;
  // divisor is the number of clocks per bit minus one
  localparam logic [15:0] BAUD_DIV_RST =
    16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT - 1);
  localparam logic [15:0] BAUD_DIV_MIN = 16'h0003;

  ////////////////////////////////////////////////////////////////////////////////
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_FLAGS  = 8'h04;
  localparam logic [7:0] OFS_MASK   = 8'h08;
  localparam logic [7:0] OFS_TXDATA = 8'h0c;
  localparam logic [7:0] OFS_RXDATA = 8'h10;
  localparam logic [7:0] OFS_BAUD   = 8'h14;
  localparam logic [7:0] OFS_STAT   = 8'h18;

  ////////////////////////////////////////////////////////////////////////////////
  // control fields
  localparam int unsigned CTRL_W        = 5;
  localparam int unsigned CTRL_MODE     = 0;
  localparam int unsigned CTRL_IRQ_EN   = 1;
  localparam int unsigned CTRL_TX_NINTH = 2;
  localparam int unsigned CTRL_RX_EN    = 3;
  localparam int unsigned CTRL_LOOP     = 4;
  localparam logic [4:0]  CTRL_RST      = 5'h00;

  // flag and mask fields, same layout
  localparam int unsigned FLAG_W       = 4;
  localparam int unsigned FLAG_RX_DONE = 0;
  localparam int unsigned FLAG_TX_DONE = 1;
  localparam int unsigned FLAG_OVERRUN = 2;
  localparam int unsigned FLAG_FRAME   = 3;
  localparam logic [3:0]  FLAGS_RST    = 4'h0;
  localparam logic [3:0]  MASK_RST     = 4'h0;

  // read-only state fields
  localparam int unsigned STAT_RX_NINTH = 0;
  localparam int unsigned STAT_TX_BUSY  = 1;
  localparam int unsigned STAT_RX_BUSY  = 2;

  localparam logic [2:0]  LAST_DATA_BIT = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic {USP_MODE_8BIT, USP_MODE_9BIT} usp_mode_t;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} usp_state_t;

  ////////////////////////////////////////////////////////////////////////////////
  // bit timing helpers
  function automatic logic usp_full_tick(input logic [15:0] cnt, input logic [15:0] div);
    return cnt >= div;
  endfunction

  function automatic logic usp_half_tick(input logic [15:0] cnt, input logic [15:0] div);
    return cnt >= {1'b0, div[15:1]};
  endfunction

endpackage

// *** design/usp_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_rx
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // control
  input  wire logic        enable_in,
  input  wire logic        mode_in,
  input  wire logic [15:0] div_in,
  // line, already synchronised
  input  wire logic        line_in,
  // result
  output logic             busy_out,
  output logic             done_out,
  output logic [7:0]       data_out,
  output logic             ninth_out,
  output logic             frame_err_out
);

  usp_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic        nbit_r, nbit_nxt;
  logic        mode_r, mode_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  data_r, data_nxt;
  logic        ninth_r, ninth_nxt;
  logic        ferr_r, ferr_nxt;
  wire  logic  tick = usp_full_tick(cnt_r, div_in);
  wire  logic  half = usp_half_tick(cnt_r, div_in);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = tick ? 16'h0000 : cnt_r + 16'h0001;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    nbit_nxt  = nbit_r;
    mode_nxt  = mode_r;
    done_nxt  = 1'b0;
    data_nxt  = data_r;
    ninth_nxt = ninth_r;
    ferr_nxt  = ferr_r;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = 16'h0000;
        if (enable_in && !line_in) begin
          mode_nxt  = mode_in;
          state_nxt = ST_START;
        end
      end
      // half a bit in, so every later sample lands mid-bit
      ST_START: if (half) begin
        cnt_nxt   = 16'h0000;
        bit_nxt   = 3'h0;
        state_nxt = line_in ? ST_IDLE : ST_DATA;
      end
      ST_DATA: if (tick) begin
        shift_nxt = {line_in, shift_r[7:1]};
        bit_nxt   = bit_r + 3'h1;
        if (bit_r == LAST_DATA_BIT) begin
          state_nxt = (mode_r == USP_MODE_9BIT) ? ST_NINTH : ST_STOP;
        end
      end
      ST_NINTH: if (tick) begin
        nbit_nxt  = line_in;
        state_nxt = ST_STOP;
      end
      ST_STOP: if (tick) begin
        done_nxt  = 1'b1;
        data_nxt  = shift_r;
        ninth_nxt = (mode_r == USP_MODE_9BIT) ? nbit_r : line_in;
        ferr_nxt  = !line_in;
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= 16'h0000;
      bit_r   <= 3'h0;
      shift_r <= 8'h00;
      nbit_r  <= 1'b0;
      mode_r  <= 1'b0;
      done_r  <= 1'b0;
      data_r  <= 8'h00;
      ninth_r <= 1'b0;
      ferr_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      nbit_r  <= nbit_nxt;
      mode_r  <= mode_nxt;
      done_r  <= done_nxt;
      data_r  <= data_nxt;
      ninth_r <= ninth_nxt;
      ferr_r  <= ferr_nxt;
    end
  end

  assign busy_out      = (state_r != ST_IDLE);
  assign done_out      = done_r;
  assign data_out      = data_r;
  assign ninth_out     = ninth_r;
  assign frame_err_out = ferr_r;

endmodule
`default_nettype wire

// *** design/usp_top.sv ***
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module usp_top
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  output logic [31:0]      rdata_out,
  // serial line
  input  wire logic        rx_line_in,
  output logic             tx_line_out,
  // interrupt
  output logic             irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [FLAG_W-1:0] flags_r, flags_nxt;
  logic [FLAG_W-1:0] mask_r, mask_nxt;
  logic [15:0]       baud_r, baud_nxt;
  logic [31:0]       rdata_r;
  logic              irq_r;
  logic              rx_meta_r;
  logic              rx_sync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  wire logic hit_ctrl   = (addr_in == OFS_CTRL);
  wire logic hit_flags  = (addr_in == OFS_FLAGS);
  wire logic hit_mask   = (addr_in == OFS_MASK);
  wire logic hit_txdata = (addr_in == OFS_TXDATA);
  wire logic hit_rxdata = (addr_in == OFS_RXDATA);
  wire logic hit_baud   = (addr_in == OFS_BAUD);
  wire logic hit_stat   = (addr_in == OFS_STAT);

  wire logic wr_ctrl   = write_in && hit_ctrl;
  wire logic wr_flags  = write_in && hit_flags;
  wire logic wr_mask   = write_in && hit_mask;
  wire logic wr_txdata = write_in && hit_txdata;
  wire logic wr_baud   = write_in && hit_baud;

  ////////////////////////////////////////////////////////////////////////////////
  // control fields
  wire logic ctl_mode   = ctrl_r[CTRL_MODE];
  wire logic ctl_irq_en = ctrl_r[CTRL_IRQ_EN];
  wire logic ctl_ninth  = ctrl_r[CTRL_TX_NINTH];
  wire logic ctl_rx_en  = ctrl_r[CTRL_RX_EN];
  wire logic ctl_loop   = ctrl_r[CTRL_LOOP];

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter
  logic tx_busy;
  logic tx_done;
  logic tx_line;

  // a write while busy is dropped; busy outlasts the done flag by the stop bit, so software polls busy
  wire logic tx_start = wr_txdata && !tx_busy;

  usp_tx u_tx (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .start_in   (tx_start),
    .data_in    (wdata_in[7:0]),
    .mode_in    (ctl_mode),
    .ninth_in   (ctl_ninth),
    .div_in     (baud_r),
    .busy_out   (tx_busy),
    .done_out   (tx_done),
    .line_out   (tx_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // receiver input: the pin is asynchronous, two flops before any logic
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_line_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  // loopback takes the transmit flop directly, same clock, no sync needed
  wire logic rx_line = ctl_loop ? tx_line : rx_sync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // receiver
  logic       rx_busy;
  logic       rx_done;
  logic [7:0] rx_data;
  logic       rx_ninth_bit;
  logic       rx_ferr;

  usp_rx u_rx (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .enable_in     (ctl_rx_en),
    .mode_in       (ctl_mode),
    .div_in        (baud_r),
    .line_in       (rx_line),
    .busy_out      (rx_busy),
    .done_out      (rx_done),
    .data_out      (rx_data),
    .ninth_out     (rx_ninth_bit),
    .frame_err_out (rx_ferr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over a same-cycle write-one clear
  wire logic [FLAG_W-1:0] flag_clr = wr_flags ? wdata_in[FLAG_W-1:0] : FLAGS_RST;

  // a new byte while the rx done flag is still set and not being cleared is an overrun
  wire logic overrun = rx_done && flags_r[FLAG_RX_DONE] && !flag_clr[FLAG_RX_DONE];

  wire logic [FLAG_W-1:0] flag_set = {
    rx_done && rx_ferr,
    overrun,
    tx_done,
    rx_done
  };

  // only flag_clr takes bits away, so hardware never drops a done flag
  assign flags_nxt = (flags_r & ~flag_clr) | flag_set;

  ////////////////////////////////////////////////////////////////////////////////
  // writable registers
  assign ctrl_nxt = wr_ctrl ? wdata_in[CTRL_W-1:0] : ctrl_r;
  assign mask_nxt = wr_mask ? wdata_in[FLAG_W-1:0] : mask_r;

  // too small a divisor would collapse the half-bit sample point
  wire logic [15:0] baud_wr = (wdata_in[15:0] < BAUD_DIV_MIN) ? BAUD_DIV_MIN
                                                              : wdata_in[15:0];
  assign baud_nxt = wr_baud ? baud_wr : baud_r;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r  <= CTRL_RST;
      flags_r <= FLAGS_RST;
      mask_r  <= MASK_RST;
      baud_r  <= BAUD_DIV_RST;
    end else begin
      ctrl_r  <= ctrl_nxt;
      flags_r <= flags_nxt;
      mask_r  <= mask_nxt;
      baud_r  <= baud_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt: one level, unmasked flags ORed and gated by the enable
  wire logic [FLAG_W-1:0] flags_live = flags_r & mask_r;
  wire logic              irq_nxt    = ctl_irq_en && (|flags_live);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: data stands in the cycle after the strobe, zero otherwise
  wire logic [31:0] rd_ctrl  = {{(32 - CTRL_W){1'b0}}, ctrl_r};
  wire logic [31:0] rd_flags = {{(32 - FLAG_W){1'b0}}, flags_r};
  wire logic [31:0] rd_mask  = {{(32 - FLAG_W){1'b0}}, mask_r};
  wire logic [31:0] rd_rx    = {24'h000000, rx_data};
  wire logic [31:0] rd_baud  = {16'h0000, baud_r};
  wire logic [31:0] rd_stat  = {29'h00000000, rx_busy, tx_busy, rx_ninth_bit};

  wire logic [31:0] rd_word =
    hit_ctrl   ? rd_ctrl  :
    hit_flags  ? rd_flags :
    hit_mask   ? rd_mask  :
    hit_rxdata ? rd_rx    :
    hit_baud   ? rd_baud  :
    hit_stat   ? rd_stat  :
    32'h00000000;

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= read_in ? rd_word : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out   = rdata_r;
  assign tx_line_out = tx_line;
  assign irq_out     = irq_r;

endmodule
`default_nettype wire

// *** design/usp_tx.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_tx
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // request
  input  wire logic        start_in,
  input  wire logic [7:0]  data_in,
  input  wire logic        mode_in,
  input  wire logic        ninth_in,
  input  wire logic [15:0] div_in,
  // state
  output logic             busy_out,
  output logic             done_out,
  // line
  output logic             line_out
);

  usp_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  shift_r, shift_nxt;
  logic        ninth_r, ninth_nxt;
  logic        mode_r, mode_nxt;
  logic        line_r, line_nxt;
  logic        done_r, done_nxt;
  wire  logic  tick = usp_full_tick(cnt_r, div_in);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = tick ? 16'h0000 : cnt_r + 16'h0001;
    bit_nxt   = bit_r;
    shift_nxt = shift_r;
    ninth_nxt = ninth_r;
    mode_nxt  = mode_r;
    line_nxt  = line_r;
    done_nxt  = 1'b0;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt  = 16'h0000;
        line_nxt = 1'b1;
        if (start_in) begin
          // ninth level is sampled once here; later writes do not tear the frame
          shift_nxt = data_in;
          ninth_nxt = ninth_in;
          mode_nxt  = mode_in;
          line_nxt  = 1'b0;
          state_nxt = ST_START;
        end
      end
      ST_START: if (tick) begin
        line_nxt  = shift_r[0];
        bit_nxt   = 3'h0;
        state_nxt = ST_DATA;
      end
      ST_DATA: if (tick) begin
        shift_nxt = {1'b0, shift_r[7:1]};
        if (bit_r == LAST_DATA_BIT) begin
          if (mode_r == USP_MODE_9BIT) begin
            line_nxt  = ninth_r;
            state_nxt = ST_NINTH;
          end else begin
            line_nxt  = 1'b1;
            done_nxt  = 1'b1;
            state_nxt = ST_STOP;
          end
        end else begin
          line_nxt = shift_r[1];
          bit_nxt  = bit_r + 3'h1;
        end
      end
      ST_NINTH: if (tick) begin
        line_nxt  = 1'b1;
        done_nxt  = 1'b1;
        state_nxt = ST_STOP;
      end
      ST_STOP: if (tick) begin
        state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= ST_IDLE;
      cnt_r   <= 16'h0000;
      bit_r   <= 3'h0;
      shift_r <= 8'h00;
      ninth_r <= 1'b0;
      mode_r  <= 1'b0;
      line_r  <= 1'b1;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      shift_r <= shift_nxt;
      ninth_r <= ninth_nxt;
      mode_r  <= mode_nxt;
      line_r  <= line_nxt;
      done_r  <= done_nxt;
    end
  end

  assign busy_out = (state_r != ST_IDLE);
  assign done_out = done_r;
  assign line_out = line_r;

endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import usp_pkg::*;
  localparam int BIT_CLKS = 16;
  localparam int LIMIT    = 10000;

  logic        clock_in    = 1'b0;
  logic        reset_n_in  = 1'b0;
  logic [7:0]  addr_in     = 8'h00;
  logic [31:0] wdata_in    = 32'h0;
  logic        write_in    = 1'b0;
  logic        read_in     = 1'b0;
  logic [31:0] rdata_out;
  logic        rx_line_in;
  logic        tx_line_out;
  logic        irq_out;
  logic        stop_phase;
  int          mismatches      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          hi_cnt          = 0;

  usp_top DUT (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
               .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
               .rdata_out(rdata_out), .rx_line_in(rx_line_in), .tx_line_out(tx_line_out),
               .irq_out(irq_out));
  usp_far_end #(.BIT_CLKS(BIT_CLKS)) FAR (.clock_in(clock_in), .tx_line_in(tx_line_out),
                                          .rx_line_out(rx_line_in),
                                          .stop_phase_out(stop_phase));

  ////////////////////////////////////////////////////////////////////////////////
  always #2 clock_in = ~clock_in;

  // hi_cnt measures how long the transmit line has stood high
  always @(posedge clock_in) begin
    hi_cnt <= tx_line_out ? hi_cnt + 1 : 0;
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    #1 v = rdata_out;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask

  task automatic wait_irq(input int limit, output int n);
    for (n = 0; n < limit && irq_out !== 1'b1; n++) tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk("ctrl reset", OFS_CTRL, 32'(CTRL_RST));
    rd_chk("flags reset", OFS_FLAGS, 32'(FLAGS_RST));
    rd_chk("mask reset", OFS_MASK, 32'(MASK_RST));
    rd_chk("baud reset", OFS_BAUD, 32'(BAUD_DIV_RST));
    rd_chk("stat reset", OFS_STAT, 32'h0);
    wr(OFS_BAUD, 32'h1);
    rd_chk("baud clamp", OFS_BAUD, 32'(BAUD_DIV_MIN));
    wr(8'h1c, 32'hffff_ffff);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(OFS_BAUD, 32'(BIT_CLKS - 1));
  endtask

  // data bit7 is low, so the line last rises at the ninth bit or the stop bit
  task automatic t_tx();
    logic [7:0] d;
    logic       nb;
    logic       sb;
    logic       ok;
    int         n;
    int         h;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_MASK, 32'h2);
      wr(OFS_CTRL, {29'h0, k[1], 1'b1, k[0]});
      wr(OFS_TXDATA, 32'h35);
      fork
        FAR.recv_frame(k[0], d, nb, sb, ok);
        begin
          wait_irq(600, n);
          h = hi_cnt;
        end
      join
      chk("tx irq", 32'h1, 32'(n < 600));
      chk("tx done point", 32'((k[0] && k[1]) ? BIT_CLKS + 2 : 2), 32'(h));
      chk("tx frame", {21'h0, 1'b1, 1'b1, k[0] && k[1], 8'h35}, {21'h0, ok, sb, nb, d});
      tick(40);
      chk("tx irq held", 32'h1, {31'h0, irq_out});
      rd_chk("tx flag held", OFS_FLAGS, 32'h2);
      rd_chk("tx ninth kept", OFS_CTRL, {29'h0, k[1], 1'b1, k[0]});
      wr(OFS_FLAGS, 32'h2);
      tick(3);
      chk("tx irq clear", 32'h0, {31'h0, irq_out});
    end
  endtask

  // in 8-bit mode k[1] is the stop level, in 9-bit mode the ninth bit
  task automatic t_rx();
    logic [31:0] v;
    logic        sp;
    int          n;
    for (int k = 0; k < 4; k++) begin
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, {28'h0, 1'b1, 1'b0, 1'b1, k[0]});
      fork
        FAR.send_frame(8'hc5, k[0], k[1], k[0] | k[1]);
        begin
          wait_irq(600, n);
          sp = stop_phase;
        end
      join
      chk("rx irq at stop", 32'h3, {30'h0, n < 600, sp});
      rd_chk("rx byte", OFS_RXDATA, 32'hc5);
      rd(OFS_STAT, v);
      chk("rx ninth", {31'h0, k[1]}, {31'h0, v[STAT_RX_NINTH]});
      tick(40);
      chk("rx irq held", 32'h1, {31'h0, irq_out});
      rd_chk("rx flag held", OFS_FLAGS, {28'h0, ~(k[0] | k[1]), 3'h1});
      wr(OFS_FLAGS, 32'hf);
      tick(3);
      chk("rx irq clear", 32'h0, {31'h0, irq_out});
      tick(20);
    end
  endtask

  task automatic t_gate();
    wr(OFS_CTRL, 32'h8);
    wr(OFS_MASK, 32'h3);
    FAR.send_frame(8'h5a, 1'b0, 1'b0, 1'b1);
    tick(8);
    chk("gate off", 32'h0, {31'h0, irq_out});
    rd_chk("gate flag", OFS_FLAGS, 32'h1);
    wr(OFS_CTRL, 32'ha);
    tick(3);
    chk("gate on", 32'h1, {31'h0, irq_out});
    wr(OFS_MASK, 32'h2);
    tick(3);
    chk("mask off", 32'h0, {31'h0, irq_out});
    wr(OFS_FLAGS, 32'hf);
  endtask

  // loopback feeds the receiver from the transmit flop; the second write lands while busy
  task automatic t_loop();
    logic [31:0] v;
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h1d);
    wr(OFS_TXDATA, 32'ha3);
    rd(OFS_STAT, v);
    chk("loop busy", 32'h3, {30'h0, v[STAT_RX_BUSY], v[STAT_TX_BUSY]});
    wr(OFS_TXDATA, 32'h11);
    tick(200);
    rd_chk("loop byte", OFS_RXDATA, 32'ha3);
    rd_chk("loop ninth", OFS_STAT, 32'h1);
    rd_chk("loop flags", OFS_FLAGS, 32'h3);
    wr(OFS_TXDATA, 32'h5c);
    tick(200);
    rd_chk("loop overrun", OFS_FLAGS, 32'h7);
    rd_chk("loop byte 2", OFS_RXDATA, 32'h5c);
    wr(OFS_FLAGS, 32'hf);
    wr(OFS_CTRL, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_regs();
    t_tx();
    t_rx();
    t_gate();
    t_loop();
    results();
  end
endmodule
`default_nettype wire

// *** sim/usp_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_far_end #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clock_in,
  input  wire logic tx_line_in,
  output var logic  rx_line_out,
  output var logic  stop_phase_out
);
  // the line idles at mark level, as a pulled-up wire would
  initial begin
    rx_line_out = 1'b1;
    stop_phase_out = 1'b0;
  end

  task automatic drive_bit(input logic b);
    rx_line_out <= b;
    repeat (BIT_CLKS) @(posedge clock_in);
  endtask

  task automatic send_frame(input logic [7:0] d, input logic nine, input logic ninth,
                            input logic stop_lvl);
    @(posedge clock_in);
    drive_bit(1'b0);
    for (int i = 0; i < 8; i++) drive_bit(d[i]);
    if (nine) drive_bit(ninth);
    stop_phase_out <= 1'b1;
    drive_bit(stop_lvl);
    stop_phase_out <= 1'b0;
    drive_bit(1'b1);
  endtask

  // samples mid-bit, so an edge landing on the clock edge cannot race the sample
  task automatic recv_frame(input logic nine, output logic [7:0] d, output logic ninth,
                            output logic stop_lvl, output logic ok);
    int i;
    d = 8'h00;
    ninth = 1'b0;
    for (i = 0; i < 4000 && tx_line_in; i++) @(posedge clock_in);
    ok = !tx_line_in;
    repeat (BIT_CLKS / 2) @(posedge clock_in);
    ok = ok && !tx_line_in;
    for (i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clock_in);
      d[i] = tx_line_in;
    end
    if (nine) begin
      repeat (BIT_CLKS) @(posedge clock_in);
      ninth = tx_line_in;
    end
    repeat (BIT_CLKS) @(posedge clock_in);
    stop_lvl = tx_line_in;
  endtask
endmodule
`default_nettype wire

// *** sim/usp_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module usp_props
  import usp_pkg::*;
(
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  input  wire logic [31:0] rdata_out,
  // serial line and interrupt
  input  wire logic        rx_line_in,
  input  wire logic        tx_line_out,
  input  wire logic        irq_out
);
  logic [4:0] ctrl_r;
  logic [3:0] mask_r;
  logic       mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // shadows of software-owned registers; hardware must never alter them
  assign mapped = addr_in inside {OFS_CTRL, OFS_FLAGS, OFS_MASK, OFS_TXDATA, OFS_RXDATA,
                                  OFS_BAUD, OFS_STAT};

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
    end else if (write_in) begin
      if (addr_in == OFS_CTRL) ctrl_r <= wdata_in[4:0];
      if (addr_in == OFS_MASK) mask_r <= wdata_in[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  a_release_idle: assert property ($rose(reset_n_in) |-> tx_line_out && !irq_out && rdata_out == 32'h0)
    else $error("outputs not idle after reset release");
  a_rdata_idle_zero: assert property (!$past(read_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside read answer");
  a_rdata_upper_zero: assert property (rdata_out[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_unmapped_read_zero: assert property (read_in && !mapped |=> rdata_out == 32'h0)
    else $error("unmapped read returned data");
  a_ctrl_read_back: assert property (read_in && addr_in == OFS_CTRL |=> rdata_out == {27'h0, ctrl_r})
    else $error("control readback differs from last write");
  a_mask_read_back: assert property (read_in && addr_in == OFS_MASK |=> rdata_out == {28'h0, mask_r})
    else $error("mask readback differs from last write");
  a_irq_needs_enable: assert property (!ctrl_r[CTRL_IRQ_EN] |=> !irq_out)
    else $error("interrupt raised while disabled");
  a_irq_needs_mask: assert property (mask_r == 4'h0 |=> !irq_out)
    else $error("interrupt raised with all sources masked");
  a_irq_fall_write: assert property ($fell(irq_out) |-> $past(write_in, 2))
    else $error("interrupt dropped without a software write");

  c_irq_rise: cover property ($rose(irq_out));
  c_tx_start: cover property ($fell(tx_line_out));
  c_flag_read: cover property (read_in && addr_in == OFS_FLAGS);
endmodule

bind usp_top usp_props CHK (
  .clock_in    (clock_in),
  .reset_n_in  (reset_n_in),
  .addr_in     (addr_in),
  .wdata_in    (wdata_in),
  .write_in    (write_in),
  .read_in     (read_in),
  .rdata_out   (rdata_out),
  .rx_line_in  (rx_line_in),
  .tx_line_out (tx_line_out),
  .irq_out     (irq_out)
);
`default_nettype wire
